/* common/sdco_consts.svh */
`ifndef SDCO_CONSTS_SVH
`define SDCO_CONSTS_SVH

// ****************************************
// Object indices
// ****************************************
`define SDCO_IDX_SUB_ERROR 16'h4001
`define SDCO_IDX_REF_POS 16'h4020
`define SDCO_IDX_CONFIG 16'h4100
`define SDCO_IDX_ENC_CLEAR 16'h4102
`define SDCO_IDX_COORD_MODE 16'h4103
`define SDCO_IDX_COORD_POS 16'h4104

// ****************************************
// Keys, reset values, codes
// ****************************************
`define SDCO_KEY_CONFIG 32'h666E_6F63
`define SDCO_KEY_ENC_CLEAR 32'h6A64_6165
`define SDCO_RST_HALF 16'h0000
`define SDCO_RST_WORD 32'h0000_0000
// Error 27.7: sub 7 in the upper byte as F7, main 27 in the lower byte
`define SDCO_FAULT_CODE 16'hF727

// ****************************************
// Status field and timing
// ****************************************
`define SDCO_STAT_READY_BIT 9
`define SDCO_OP_CYCLES 16
`define SDCO_OP_CNT_W 8

`endif

/* common/sdco_pkg.sv */
package sdco_pkg;

  typedef logic [31:0] sdco_word_t;
  typedef logic [15:0] sdco_half_t;

  typedef enum logic [1:0]
  {
    sdco_trig_idle = 2'b00,
    sdco_trig_run = 2'b01,
    sdco_trig_fault = 2'b10
  } sdco_trig_state_t;

endpackage

/* core/sdco_objects.sv */
// How it works
// - Ready flag reads 1 when commands can be taken, 0 when not.
// - Ready held low during mailbox writes, config, resets, clears, saves, encoder setup.
// - Ready low from enable-operation acceptance until motor is energised.
// - Ready low from disable, shutdown or disable-voltage until de-energised.
// - Sub error code is read-only, mappable, reflects errors, resets to zero.
// - Reference position gives starting command position when entering position mode.
// - In cyclic position mode the reference position shows following error.
// - Mapping reference position with short cycle or non-unity gear raises 93.4.
// - Config key written by mailbox applies changes to attribute C objects.
// - Config while energised forces the motor de-energised.
// - Completed configuration enters fault with error 27.7.
// - Config write aborts on complete access, wrong key, or undervoltage 11.0.
// - Encoder key written by mailbox clears the multi-turn counter.
// - Completed multi-turn clear enters fault with error 27.7.
// - Encoder write aborts on complete access, wrong key, or semi-closed while on.
// - Coordinate setting mode object: 16 bits, mappable, resets to zero.
// - Coordinate setting position object: signed 32 bits, mappable.
// - Ready flag is bit 9 of a 16-bit status field, 1 means accepting.
`include "sdco_consts.svh"

module sdco_objects
#(
  parameter int OP_CYCLES = `SDCO_OP_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Mailbox object access
  input wire logic mbx_req,
  input wire logic mbx_write,
  input wire logic mbx_complete,
  input wire sdco_pkg::sdco_half_t mbx_index,
  input wire sdco_pkg::sdco_word_t mbx_wdata,
  output logic mbx_ack,
  output logic mbx_abort,
  output sdco_pkg::sdco_word_t mbx_rdata,
  // Drive state
  input wire logic motor_energised,
  input wire logic enable_op_accept,
  input wire logic disable_op_accept,
  input wire logic fault_reset_busy,
  input wire logic history_clear_busy,
  input wire logic backup_busy,
  input wire logic save_busy,
  input wire logic restore_busy,
  input wire logic undervoltage_err,
  input wire logic semi_closed_abs,
  // Error reporting
  input wire logic err_valid,
  input wire sdco_pkg::sdco_half_t err_code,
  input wire logic err_clear,
  // Position sources
  input wire logic csp_mode,
  input wire sdco_pkg::sdco_word_t position_cmd_units,
  input wire sdco_pkg::sdco_word_t following_error,
  input wire logic ref_pos_mapped,
  input wire logic cycle_short,
  input wire logic gear_not_unity,
  // Coordinate setting sources
  input wire sdco_pkg::sdco_half_t coord_mode_in,
  input wire sdco_pkg::sdco_word_t coord_pos_in,
  // Object values
  output logic command_accept_ready,
  output sdco_pkg::sdco_half_t mfr_status,
  output sdco_pkg::sdco_half_t sub_error_detail,
  output sdco_pkg::sdco_word_t ref_position,
  output sdco_pkg::sdco_half_t coord_mode,
  output sdco_pkg::sdco_word_t coord_position,
  // Actions
  output logic func_setting_error,
  output logic force_deenergise,
  output logic config_apply,
  output logic multiturn_clear,
  output logic fault_request
);
  import sdco_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic next_ack;
  logic next_abort;
  sdco_word_t next_rdata;
  logic cfg_start;
  logic enc_start;
  logic cfg_busy;
  logic enc_busy;
  logic cfg_action;
  logic enc_action;
  logic cfg_fault;
  logic enc_fault;
  logic wr_pend;
  logic next_wr_pend;
  logic on_pend;
  logic next_on_pend;
  logic off_pend;
  logic next_off_pend;
  logic next_ready;
  sdco_word_t config_trigger;
  sdco_word_t next_config_trigger;
  sdco_word_t encoder_multiturn_clear;
  sdco_word_t next_encoder_multiturn_clear;
  sdco_half_t next_sub_error;
  sdco_word_t next_ref_position;
  sdco_half_t next_coord_mode;
  sdco_word_t next_coord_position;
  logic next_func_err;
  logic next_force_off;
  logic servo_not_off;

  // ****************************************
  // Keyed trigger sequencers
  // ****************************************
  sdco_trigger #(.OP_CYCLES(OP_CYCLES)) u_cfg_trig
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(cfg_start),
    .busy(cfg_busy),
    .action(cfg_action),
    .fault(cfg_fault)
  );

  sdco_trigger #(.OP_CYCLES(OP_CYCLES)) u_enc_trig
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(enc_start),
    .busy(enc_busy),
    .action(enc_action),
    .fault(enc_fault)
  );

  // ****************************************
  // Mailbox decode
  // ****************************************
  // Pending servo-on (on_pend) counts as not off
  assign servo_not_off = motor_energised | on_pend;

  always_comb
  begin
    next_ack = mbx_req;
    next_abort = 1'b0;
    next_rdata = `SDCO_RST_WORD;
    cfg_start = 1'b0;
    enc_start = 1'b0;
    next_config_trigger = config_trigger;
    next_encoder_multiturn_clear = encoder_multiturn_clear;
    if (mbx_req)
    begin
      case (mbx_index)
        `SDCO_IDX_SUB_ERROR:
        begin
          next_rdata = {16'h0000, sub_error_detail};
          next_abort = mbx_write;
        end
        `SDCO_IDX_REF_POS:
        begin
          next_rdata = ref_position;
          next_abort = mbx_write;
        end
        `SDCO_IDX_COORD_MODE:
        begin
          next_rdata = {16'h0000, coord_mode};
          next_abort = mbx_write;
        end
        `SDCO_IDX_COORD_POS:
        begin
          next_rdata = coord_position;
          next_abort = mbx_write;
        end
        `SDCO_IDX_CONFIG:
        begin
          next_rdata = config_trigger;
          if (mbx_write)
          begin
            if (mbx_complete || mbx_wdata != `SDCO_KEY_CONFIG || undervoltage_err ||
                cfg_busy)
              next_abort = 1'b1;
            else
            begin
              cfg_start = 1'b1;
              next_config_trigger = mbx_wdata;
            end
          end
        end
        `SDCO_IDX_ENC_CLEAR:
        begin
          next_rdata = encoder_multiturn_clear;
          if (mbx_write)
          begin
            if (mbx_complete || mbx_wdata != `SDCO_KEY_ENC_CLEAR ||
                (semi_closed_abs && servo_not_off) || enc_busy)
              next_abort = 1'b1;
            else
            begin
              enc_start = 1'b1;
              next_encoder_multiturn_clear = mbx_wdata;
            end
          end
        end
        default:
          next_abort = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mbx_ack <= 1'b0;
      mbx_abort <= 1'b0;
      mbx_rdata <= `SDCO_RST_WORD;
      config_trigger <= `SDCO_RST_WORD;
      encoder_multiturn_clear <= `SDCO_RST_WORD;
    end
    else
    begin
      mbx_ack <= next_ack;
      mbx_abort <= next_abort;
      mbx_rdata <= next_rdata;
      config_trigger <= next_config_trigger;
      encoder_multiturn_clear <= next_encoder_multiturn_clear;
    end
  end

  // ****************************************
  // Command acceptance ready
  // ****************************************
  always_comb
  begin
    next_wr_pend = mbx_req & mbx_write;
    next_on_pend = enable_op_accept | (on_pend & ~motor_energised);
    next_off_pend = disable_op_accept | (off_pend & motor_energised);
    next_ready = ~(next_wr_pend | wr_pend | cfg_start | enc_start | cfg_busy | enc_busy |
                   fault_reset_busy | history_clear_busy | backup_busy | save_busy |
                   restore_busy | next_on_pend | next_off_pend);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      wr_pend <= 1'b0;
      on_pend <= 1'b0;
      off_pend <= 1'b0;
      command_accept_ready <= 1'b0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      on_pend <= next_on_pend;
      off_pend <= next_off_pend;
      command_accept_ready <= next_ready;
    end
  end

  // Ready in bit 9, other bits zero
  always_comb
  begin
    mfr_status = 16'h0000;
    mfr_status[`SDCO_STAT_READY_BIT] = command_accept_ready;
  end

  // ****************************************
  // Error, position and coordinate objects
  // ****************************************
  always_comb
  begin
    next_sub_error = sub_error_detail;
    if (err_clear)
      next_sub_error = `SDCO_RST_HALF;
    if (err_valid)
      next_sub_error = err_code;
    if (cfg_fault || enc_fault)
      next_sub_error = `SDCO_FAULT_CODE;
    next_ref_position = csp_mode ? following_error : position_cmd_units;
    next_func_err = ref_pos_mapped & (cycle_short | gear_not_unity);
    next_coord_mode = coord_mode_in;
    next_coord_position = coord_pos_in;
    next_force_off = cfg_start & servo_not_off;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sub_error_detail <= `SDCO_RST_HALF;
      ref_position <= `SDCO_RST_WORD;
      func_setting_error <= 1'b0;
      coord_mode <= `SDCO_RST_HALF;
      coord_position <= `SDCO_RST_WORD;
      force_deenergise <= 1'b0;
      config_apply <= 1'b0;
      multiturn_clear <= 1'b0;
      fault_request <= 1'b0;
    end
    else
    begin
      sub_error_detail <= next_sub_error;
      ref_position <= next_ref_position;
      func_setting_error <= next_func_err;
      coord_mode <= next_coord_mode;
      coord_position <= next_coord_position;
      force_deenergise <= next_force_off;
      config_apply <= cfg_action;
      multiturn_clear <= enc_action;
      fault_request <= cfg_fault | enc_fault;
    end
  end

endmodule

/* core/sdco_trigger.sv */
`include "sdco_consts.svh"

module sdco_trigger
#(
  parameter int OP_CYCLES = `SDCO_OP_CYCLES,
  parameter int CNT_W = `SDCO_OP_CNT_W
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  // Status
  output logic busy,
  output logic action,
  output logic fault
);
  import sdco_pkg::*;

  sdco_trig_state_t state;
  sdco_trig_state_t next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_action;

  generate
    if (OP_CYCLES < 1 || OP_CYCLES >= (1 << CNT_W))
    begin : g_bad_cycles
      $error("OP_CYCLES does not fit the counter");
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_action = 1'b0;
    case (state)
      sdco_trig_idle:
      begin
        if (start)
        begin
          next_state = sdco_trig_run;
          next_count = CNT_W'(OP_CYCLES - 1);
          next_action = 1'b1;
        end
      end
      sdco_trig_run:
      begin
        if (count == '0)
          next_state = sdco_trig_fault;
        else
          next_count = count - 1'b1;
      end
      sdco_trig_fault:
        next_state = sdco_trig_idle;
      default:
        next_state = sdco_trig_idle;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= sdco_trig_idle;
      count <= '0;
      action <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      action <= next_action;
    end
  end

  // Busy spans the fault cycle too
  assign busy = (state != sdco_trig_idle);
  assign fault = (state == sdco_trig_fault);

endmodule

/* sim/sdco_checker.sv */
`include "sdco_consts.svh"

module sdco_checker
#(
  parameter int OP_CYCLES = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Mailbox
  input wire logic mbx_req,
  input wire logic mbx_write,
  input wire sdco_pkg::sdco_half_t mbx_index,
  input wire sdco_pkg::sdco_word_t mbx_wdata,
  input wire logic mbx_ack,
  input wire logic mbx_abort,
  // Drive state
  input wire logic motor_energised,
  input wire logic enable_op_accept,
  input wire logic disable_op_accept,
  input wire logic ref_pos_mapped,
  input wire logic cycle_short,
  input wire logic gear_not_unity,
  // Watched outputs
  input wire logic command_accept_ready,
  input wire sdco_pkg::sdco_half_t mfr_status,
  input wire sdco_pkg::sdco_half_t sub_error_detail,
  input wire logic func_setting_error,
  input wire logic force_deenergise,
  input wire logic config_apply,
  input wire logic multiturn_clear,
  input wire logic fault_request
);
  import sdco_pkg::*;
  // ****************
  // Helpers
  // ****************
  logic cfg_wr;
  logic enc_wr;
  int run_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  assign cfg_wr = mbx_req && mbx_write && mbx_index == `SDCO_IDX_CONFIG;
  assign enc_wr = mbx_req && mbx_write && mbx_index == `SDCO_IDX_ENC_CLEAR;
  // Counts from launch so a too-short run shows up
  always_ff @(posedge sys_clk)
    run_cnt <= (!reset_n || config_apply || multiturn_clear) ? 0 : run_cnt + 1;
  // ****************
  // Properties
  // ****************
  AST_STATUS_BIT: assert property (mfr_status == {6'h00, command_accept_ready, 9'h000})
    else $error("status field bit mismatch");
  AST_WRITE_BUSY: assert property (mbx_req && mbx_write |=> !command_accept_ready)
    else $error("ready high after write");
  AST_ON_PENDING: assert property (enable_op_accept ##1 !motor_energised [*3] |-> !command_accept_ready)
    else $error("ready high before energised");
  AST_OFF_PENDING: assert property (disable_op_accept ##1 motor_energised [*3] |-> !command_accept_ready)
    else $error("ready high before de-energised");
  AST_FUNC_ERR: assert property ($past(reset_n) |-> func_setting_error == $past(ref_pos_mapped && (cycle_short || gear_not_unity)))
    else $error("setting error wrong");
  AST_BAD_CFG_KEY: assert property (cfg_wr && mbx_wdata != `SDCO_KEY_CONFIG |=> mbx_ack && mbx_abort)
    else $error("bad config key taken");
  AST_BAD_ENC_KEY: assert property (enc_wr && mbx_wdata != `SDCO_KEY_ENC_CLEAR |=> mbx_ack && mbx_abort)
    else $error("bad encoder key taken");
  AST_APPLY: assert property (cfg_wr ##1 mbx_ack && !mbx_abort |=> config_apply)
    else $error("config not applied");
  AST_FORCE_OFF: assert property (cfg_wr && motor_energised ##1 mbx_ack && !mbx_abort |-> force_deenergise)
    else $error("motor not forced off");
  AST_MT_CLEAR: assert property (enc_wr ##1 mbx_ack && !mbx_abort |=> multiturn_clear)
    else $error("multi-turn not cleared");
  AST_FAULT_WAIT: assert property (config_apply || multiturn_clear |-> !command_accept_ready throughout (##[1:300] fault_request))
    else $error("keyed run end wrong");
  AST_FAULT_CODE: assert property (fault_request |-> ##[0:1] sub_error_detail == `SDCO_FAULT_CODE)
    else $error("fault code missing");
  AST_RUN_LEN: assert property (fault_request |-> run_cnt == OP_CYCLES - 1)
    else $error("keyed run too short");
endmodule

/* sim/sdco_mbx_master.sv */
module sdco_mbx_master
(
  // Clock
  input wire logic sys_clk,
  // Mailbox request
  output logic mbx_req,
  output logic mbx_write,
  output logic mbx_complete,
  output sdco_pkg::sdco_half_t mbx_index,
  output sdco_pkg::sdco_word_t mbx_wdata
);
  import sdco_pkg::*;
  // ****************
  // Requests
  // ****************
  initial
  begin
    mbx_req = 1'b0;
    {mbx_write, mbx_complete, mbx_index, mbx_wdata} = '0;
  end
  // One request, held only for its taking edge
  task automatic access(input logic wr, input logic cpl, input sdco_half_t idx,
    input sdco_word_t data);
    @(posedge sys_clk);
    #1;
    {mbx_req, mbx_write, mbx_complete, mbx_index, mbx_wdata} = {1'b1, wr, cpl, idx, data};
    @(posedge sys_clk);
    #1;
    // Released qualifiers scrambled, never left at the last value
    {mbx_req, mbx_write, mbx_complete, mbx_index, mbx_wdata} = {1'b0, ~wr, ~cpl, ~idx, ~data};
  endtask
  // switch only at constant speed, same gain; this model never switches
  function automatic sdco_word_t csp_target(input sdco_word_t ref_pos, input sdco_word_t step);
    return ref_pos + step;
  endfunction
endmodule

/* sim/testbench.sv */
`include "sdco_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sdco_pkg::*;
  // ****************
  // Signals
  // ****************
  localparam int OPC = 2;
  localparam sdco_word_t KC = `SDCO_KEY_CONFIG;
  localparam sdco_word_t KE = `SDCO_KEY_ENC_CLEAR;
  localparam logic [33:0] AB = {2'b01, 32'h0};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic motor_energised, enable_op_accept, disable_op_accept, undervoltage_err, semi_closed_abs;
  logic err_valid, err_clear, csp_mode, ref_pos_mapped, cycle_short, gear_not_unity;
  logic [4:0] busy_v;
  logic mbx_req, mbx_write, mbx_complete, mbx_ack, mbx_abort, command_accept_ready;
  logic func_setting_error, force_deenergise, config_apply, multiturn_clear, fault_request;
  sdco_half_t mbx_index, err_code, coord_mode_in, mfr_status, sub_error_detail, coord_mode;
  sdco_word_t mbx_wdata, position_cmd_units, following_error, coord_pos_in, mbx_rdata;
  sdco_word_t ref_position, coord_position;
  sdco_half_t ro_idx[4] = '{`SDCO_IDX_SUB_ERROR, `SDCO_IDX_REF_POS, `SDCO_IDX_COORD_MODE,
    `SDCO_IDX_COORD_POS};
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int mismatches = 0, tests_run = 0, cycles = 0, n_apply = 0, n_mt = 0, n_off = 0;

  always #2.5 sys_clk = ~sys_clk;

  sdco_mbx_master master (.sys_clk, .mbx_req, .mbx_write, .mbx_complete, .mbx_index,
    .mbx_wdata);
  sdco_objects #(.OP_CYCLES(OPC)) DUT (.sys_clk, .reset_n, .mbx_req, .mbx_write, .mbx_complete,
    .mbx_index, .mbx_wdata, .mbx_ack, .mbx_abort, .mbx_rdata, .motor_energised,
    .enable_op_accept, .disable_op_accept, .fault_reset_busy(busy_v[0]),
    .history_clear_busy(busy_v[1]), .backup_busy(busy_v[2]), .save_busy(busy_v[3]),
    .restore_busy(busy_v[4]), .undervoltage_err, .semi_closed_abs, .err_valid, .err_code,
    .err_clear, .csp_mode, .position_cmd_units, .following_error, .ref_pos_mapped,
    .cycle_short, .gear_not_unity, .coord_mode_in, .coord_pos_in, .command_accept_ready,
    .mfr_status, .sub_error_detail, .ref_position, .coord_mode, .coord_position,
    .func_setting_error, .force_deenergise, .config_apply, .multiturn_clear, .fault_request);

  // ****************
  // Tasks
  // ****************
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Expected answer is {data checked, abort, data}
  task automatic mbx(input logic wr, input logic cpl, input sdco_half_t idx, input sdco_word_t d,
    input logic [33:0] exp);
    exp_q.push_back(exp);
    master.access(wr, cpl, idx, d);
  endtask
  task automatic wait_fault();
    int n;
    n = 0;
    while (fault_request !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    check("fault request", n < 300, 1'b1);
    check("fault code", sub_error_detail, `SDCO_FAULT_CODE);
    tick(4);
    check("ready after run", command_accept_ready, 1'b1);
  endtask

  // ****************
  // Monitor and timeout
  // ****************
  always @(negedge sys_clk)
  begin
    n_apply += (config_apply === 1'b1);
    n_mt += (multiturn_clear === 1'b1);
    n_off += (force_deenergise === 1'b1);
    if (mbx_ack === 1'b1)
    begin
      e = exp_q.pop_front();
      check("mailbox answer", {e[33], mbx_abort, e[33] ? mbx_rdata : e[31:0]}, e);
    end
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    {motor_energised, enable_op_accept, disable_op_accept, undervoltage_err} = '0;
    {semi_closed_abs, err_valid, err_clear, csp_mode, ref_pos_mapped} = '0;
    {cycle_short, gear_not_unity, busy_v} = '0;
    void'($urandom(32'h6AC6));
    err_code = 16'($urandom());
    coord_mode_in = 16'($urandom());
    coord_pos_in = $urandom();
    position_cmd_units = $urandom();
    following_error = $urandom();
    tick(20);
    check("ready in reset", command_accept_ready, 1'b0);
    check("coord mode reset", coord_mode, 16'h0000);
    check("sub error reset", sub_error_detail, 16'h0000);
    reset_n = 1'b1;
    tick(3);
    check("ready idle", command_accept_ready, 1'b1);
    check("status field", mfr_status, 16'h0200);
    mbx(0, 0, `SDCO_IDX_CONFIG, 0, {2'b10, 32'h0});
    mbx(0, 0, `SDCO_IDX_COORD_MODE, 0, {2'b10, 16'h0000, coord_mode_in});
    mbx(0, 0, `SDCO_IDX_COORD_POS, 0, {2'b10, coord_pos_in});
    mbx(0, 0, `SDCO_IDX_REF_POS, 0, {2'b10, position_cmd_units});
    csp_mode = 1'b1;
    tick(2);
    mbx(0, 0, `SDCO_IDX_REF_POS, 0, {2'b10, following_error});
    foreach (ro_idx[i])
      mbx(1, 0, ro_idx[i], $urandom(), AB);
    check("ready on write", command_accept_ready, 1'b0);
    err_valid = 1'b1;
    tick(1);
    err_valid = 1'b0;
    tick(1);
    mbx(0, 0, `SDCO_IDX_SUB_ERROR, 0, {2'b10, 16'h0000, err_code});
    for (int i = 0; i < 8; i++)
    begin
      {ref_pos_mapped, cycle_short, gear_not_unity} = i[2:0];
      tick(2);
      check("setting error", func_setting_error, i > 4);
    end
    for (int i = 0; i < 5; i++)
    begin
      busy_v = 5'h01 << i;
      tick(2);
      check("ready busy", command_accept_ready, 1'b0);
      busy_v = 5'h00;
      tick(3);
      check("ready freed", command_accept_ready, 1'b1);
    end
    enable_op_accept = 1'b1;
    tick(1);
    enable_op_accept = 1'b0;
    tick(4);
    check("ready turning on", command_accept_ready, 1'b0);
    motor_energised = 1'b1;
    tick(3);
    check("ready on", command_accept_ready, 1'b1);
    disable_op_accept = 1'b1;
    tick(1);
    disable_op_accept = 1'b0;
    tick(4);
    check("ready turning off", command_accept_ready, 1'b0);
    motor_energised = 1'b0;
    tick(3);
    check("ready off", command_accept_ready, 1'b1);
    mbx(1, 1, `SDCO_IDX_CONFIG, KC, AB);
    mbx(1, 0, `SDCO_IDX_CONFIG, KC ^ ($urandom() | 32'h1), AB);
    undervoltage_err = 1'b1;
    mbx(1, 0, `SDCO_IDX_CONFIG, KC, AB);
    undervoltage_err = 1'b0;
    motor_energised = 1'b1;
    mbx(1, 0, `SDCO_IDX_CONFIG, KC, {2'b00, 32'h0});
    check("ready in config", command_accept_ready, 1'b0);
    mbx(1, 0, `SDCO_IDX_CONFIG, KC, AB);
    wait_fault();
    motor_energised = 1'b0;
    check("config applied", n_apply, 1);
    check("forced off", n_off, 1);
    mbx(0, 0, `SDCO_IDX_CONFIG, 0, {2'b10, KC});
    err_clear = 1'b1;
    tick(1);
    err_clear = 1'b0;
    tick(1);
    check("sub error cleared", sub_error_detail, 16'h0000);
    semi_closed_abs = 1'b1;
    motor_energised = 1'b1;
    mbx(1, 0, `SDCO_IDX_ENC_CLEAR, KE, AB);
    motor_energised = 1'b0;
    mbx(1, 1, `SDCO_IDX_ENC_CLEAR, KE, AB);
    mbx(1, 0, `SDCO_IDX_ENC_CLEAR, KC, AB);
    mbx(1, 0, `SDCO_IDX_ENC_CLEAR, KE, {2'b00, 32'h0});
    wait_fault();
    check("multi-turn cleared", n_mt, 1);
    tick(3);
    check("answers left", exp_q.size(), 0);
    give_verdict();
  end
endmodule

bind sdco_objects sdco_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (.sys_clk, .reset_n, .mbx_req,
  .mbx_write, .mbx_index, .mbx_wdata, .mbx_ack, .mbx_abort, .motor_energised,
  .enable_op_accept, .disable_op_accept, .ref_pos_mapped, .cycle_short, .gear_not_unity,
  .command_accept_ready, .mfr_status, .sub_error_detail, .func_setting_error,
  .force_deenergise, .config_apply, .multiturn_clear, .fault_request);
